/* verilog/adcsq_pkg.sv */
// constants and types shared by the converter sequencer files
package adcsq_pkg;

  localparam int ADCSQ_NUM_CH = 8;
  localparam int ADCSQ_RES_W  = 10;
  localparam int ADCSQ_EVT_N  = 3;

  // byte offsets on the register bus
  localparam logic [7:0] ADCSQ_OFF_CTRL     = 8'h00;
  localparam logic [7:0] ADCSQ_OFF_START    = 8'h04;
  localparam logic [7:0] ADCSQ_OFF_AVAIL    = 8'h08;
  localparam logic [7:0] ADCSQ_OFF_EVT_STAT = 8'h0c;
  localparam logic [7:0] ADCSQ_OFF_EVT_CLR  = 8'h10;
  localparam logic [7:0] ADCSQ_OFF_EVT_EN   = 8'h14;
  localparam logic [7:0] ADCSQ_OFF_RES_BASE = 8'h20;

  // converter_control field positions
  localparam int ADCSQ_CTRL_CHSEL = 0;
  localparam int ADCSQ_CTRL_IRQEN = 3;
  localparam int ADCSQ_CTRL_CD    = 4;
  localparam int ADCSQ_CTRL_MULT  = 5;
  localparam int ADCSQ_CTRL_SCAN  = 6;
  localparam int ADCSQ_CTRL_EN    = 7;
  localparam int ADCSQ_CTRL_PRIO  = 8;
  localparam int ADCSQ_CTRL_CTX   = 11;
  localparam int ADCSQ_START_BIT  = 0;

  localparam logic [2:0] ADCSQ_MASTER_CTX = 3'h0;
  localparam logic [2:0] ADCSQ_CTX_MAX    = 3'h4;
  localparam logic [2:0] ADCSQ_FIRST_CH   = 3'h0;
  localparam logic [2:0] ADCSQ_LAST_CH    = 3'h7;
  localparam logic [6:0] ADCSQ_EXC_NUM    = 7'h4c;

  // reset values
  localparam logic [2:0] ADCSQ_RST_F3  = 3'h0;
  localparam logic       ADCSQ_RST_BIT = 1'b0;
  localparam logic [31:0] ADCSQ_RST_W  = 32'h0000_0000;

  // event status bits
  localparam int ADCSQ_EVT_DONE  = 0;
  localparam int ADCSQ_EVT_STORE = 1;
  localparam int ADCSQ_EVT_OVER  = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } adcsq_state_type;

endpackage

/* verilog/adcsq_result_mem.sv */
// per-channel result store with registered read port
`timescale 1ns/1ps
module adcsq_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 10
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]         rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // small enough to live in flops, so reset clears every word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

/* verilog/adcsq_evt_irq.sv */
// sticky event status, write-one clear, enable mask, level interrupt
`timescale 1ns/1ps
module adcsq_evt_irq #(
  parameter int N = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] evt_i,
  input  wire logic         clr_wr_i,
  input  wire logic         en_wr_i,
  input  wire logic [N-1:0] wdata_i,
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] enable_o,
  output logic              irq_o
);

  logic [N-1:0] next_status;
  logic [N-1:0] next_enable;

  always_comb begin
    // a new event beats a clear landing in the same cycle
    next_status = (status_o & ~(clr_wr_i ? wdata_i : '0)) | evt_i;
    next_enable = en_wr_i ? wdata_i : enable_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      enable_o <= '0;
      irq_o    <= 1'b0;
    end else begin
      status_o <= next_status;
      enable_o <= next_enable;
      irq_o    <= |(next_status & next_enable);
    end
  end

endmodule

/* verilog/adcsq_top.sv */
// converter sequencer: wishbone registers, channel sequencing, results
//
// Summary of operation
// - single mode converts only the selected channel; select ignored in multi
// - multi mode converts channels zero to seven, storing each result at once
// - done flag sets after the channel, or after channel seven in multi
// - control read clears the done flag and drops the converter request
// - start begins a pass, reads one while running, self-clears at end
// - writes to start are ignored while it reads one
// - with scan set, passes repeat until scan or enable is cleared
// - scanning wraps seven to zero in multi, repeats the selected channel in single, overwriting unread results
// - enable powers the core; clearing it halts any conversion
// - request raised on each done flag when interrupt enable is set
// - request goes to the context code; 101 to 111 reserved
// - request carries a three-bit priority from zero to seven
// - context field written only from the master context
// - available bit of a channel sets when its result is stored
// - reading a result clears only that channel's available bit
// - results sit in the low ten bits, upper bits read zero
// - a result stays until a newer conversion of that channel
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int NUM_CH = ADCSQ_NUM_CH,
  parameter int RES_W  = ADCSQ_RES_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [2:0]        bus_ctx_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   core_en_o,
  output logic                   core_start_o,
  output logic      [2:0]        core_chan_o,
  input  wire logic              core_done_i,
  input  wire logic [RES_W-1:0]  core_data_i,
  output logic                   conv_irq_o,
  output logic      [2:0]        irq_ctx_o,
  output logic      [2:0]        irq_prio_o,
  output logic                   irq_o
);

  if (NUM_CH != 8) begin : g_bad_ch
    $error("channel count must be eight for a three-bit select");
  end
  if (RES_W < 1 || RES_W > 32) begin : g_bad_w
    $error("result width must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////
  // declarations

  adcsq_state_type     state;
  logic                scan;
  logic                mult;
  logic                irq_en;
  logic [2:0]          chsel;
  logic                cd_flag;
  logic                start_flag;
  logic [NUM_CH-1:0]   avail;
  logic [RES_W-1:0]    mem_rdata;
  logic                rd_phase;
  logic [31:0]         next_rdata;
  logic [ADCSQ_EVT_N-1:0] evt_stat;
  logic [ADCSQ_EVT_N-1:0] evt_en;

  logic                req;
  logic                acc_wr;
  logic                acc_rd;
  logic [5:0]          widx;
  logic                hit_ctrl;
  logic                hit_start;
  logic                hit_avail;
  logic                hit_stat;
  logic                hit_clr;
  logic                hit_en;
  logic                hit_res;
  logic                store;
  logic                pass_done;
  logic                pass_stop;
  logic                overrun;
  logic [NUM_CH-1:0]   set_mask;
  logic [NUM_CH-1:0]   clr_mask;
  logic [2:0]          first_ch;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  assign req    = wb_cyc_i & wb_stb_i;
  // side effects land on the edge where the master samples ack
  assign acc_wr = req & wb_ack_o & wb_we_i;
  assign acc_rd = req & wb_ack_o & ~wb_we_i;
  assign widx   = wb_adr_i[7:2];

  always_comb begin
    hit_ctrl  = 1'b0;
    hit_start = 1'b0;
    hit_avail = 1'b0;
    hit_stat  = 1'b0;
    hit_clr   = 1'b0;
    hit_en    = 1'b0;
    hit_res   = 1'b0;
    if (widx == ADCSQ_OFF_CTRL[7:2]) begin
      hit_ctrl = 1'b1;
    end else if (widx == ADCSQ_OFF_START[7:2]) begin
      hit_start = 1'b1;
    end else if (widx == ADCSQ_OFF_AVAIL[7:2]) begin
      hit_avail = 1'b1;
    end else if (widx == ADCSQ_OFF_EVT_STAT[7:2]) begin
      hit_stat = 1'b1;
    end else if (widx == ADCSQ_OFF_EVT_CLR[7:2]) begin
      hit_clr = 1'b1;
    end else if (widx == ADCSQ_OFF_EVT_EN[7:2]) begin
      hit_en = 1'b1;
    end else if (widx[5:3] == ADCSQ_OFF_RES_BASE[7:5]) begin
      hit_res = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data; unmapped words and the clear register read zero

  always_comb begin
    next_rdata = ADCSQ_RST_W;
    if (hit_ctrl) begin
      next_rdata[ADCSQ_CTRL_CHSEL +: 3] = chsel;
      next_rdata[ADCSQ_CTRL_IRQEN]      = irq_en;
      next_rdata[ADCSQ_CTRL_CD]         = cd_flag;
      next_rdata[ADCSQ_CTRL_MULT]       = mult;
      next_rdata[ADCSQ_CTRL_SCAN]       = scan;
      next_rdata[ADCSQ_CTRL_EN]         = core_en_o;
      next_rdata[ADCSQ_CTRL_PRIO +: 3]  = irq_prio_o;
      next_rdata[ADCSQ_CTRL_CTX +: 3]   = irq_ctx_o;
    end else if (hit_start) begin
      next_rdata[ADCSQ_START_BIT] = start_flag;
    end else if (hit_avail) begin
      next_rdata[NUM_CH-1:0] = avail;
    end else if (hit_stat) begin
      next_rdata[ADCSQ_EVT_N-1:0] = evt_stat;
    end else if (hit_en) begin
      next_rdata[ADCSQ_EVT_N-1:0] = evt_en;
    end else if (hit_res) begin
      next_rdata[RES_W-1:0] = mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wishbone handshake: one cycle to fetch the result word, then ack

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_phase <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= ADCSQ_RST_W;
    end else begin
      rd_phase <= req & ~wb_ack_o & ~rd_phase;
      wb_ack_o <= rd_phase & req;
      if (rd_phase & req) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // converter_control fields

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_en_o <= ADCSQ_RST_BIT;
      scan      <= ADCSQ_RST_BIT;
      mult      <= ADCSQ_RST_BIT;
      irq_en    <= ADCSQ_RST_BIT;
      chsel     <= ADCSQ_RST_F3;
    end else if (acc_wr & hit_ctrl & wb_sel_i[0]) begin
      core_en_o <= wb_dat_i[ADCSQ_CTRL_EN];
      scan      <= wb_dat_i[ADCSQ_CTRL_SCAN];
      mult      <= wb_dat_i[ADCSQ_CTRL_MULT];
      irq_en    <= wb_dat_i[ADCSQ_CTRL_IRQEN];
      chsel     <= wb_dat_i[ADCSQ_CTRL_CHSEL +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_prio_o <= ADCSQ_RST_F3;
    end else if (acc_wr & hit_ctrl & wb_sel_i[1]) begin
      irq_prio_o <= wb_dat_i[ADCSQ_CTRL_PRIO +: 3];
    end
  end

  // reserved context codes are refused so the field always names a context
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ctx_o <= ADCSQ_RST_F3;
    end else if (acc_wr & hit_ctrl & wb_sel_i[1]) begin
      if (bus_ctx_i == ADCSQ_MASTER_CTX &&
          wb_dat_i[ADCSQ_CTRL_CTX +: 3] <= ADCSQ_CTX_MAX) begin
        irq_ctx_o <= wb_dat_i[ADCSQ_CTRL_CTX +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer status terms

  assign store     = (state == ST_WAIT) & core_en_o & core_done_i;
  assign pass_done = store & (~mult | (core_chan_o == ADCSQ_LAST_CH));
  assign pass_stop = pass_done & ~scan;
  assign overrun   = store & avail[core_chan_o];
  assign first_ch  = mult ? ADCSQ_FIRST_CH : chsel;

  ////////////////////////////////////////////////////////////////////
  // start bit

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_flag <= ADCSQ_RST_BIT;
    end else if (~core_en_o) begin
      start_flag <= 1'b0;
    end else if (pass_stop) begin
      start_flag <= 1'b0;
    end else if (acc_wr & hit_start & wb_sel_i[0] & ~start_flag) begin
      start_flag <= wb_dat_i[ADCSQ_START_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel sequencer

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      core_chan_o  <= ADCSQ_FIRST_CH;
      core_start_o <= 1'b0;
    end else begin
      core_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_flag & core_en_o) begin
            core_chan_o <= first_ch;
            state       <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (~core_en_o |
              (acc_wr & hit_ctrl & wb_sel_i[0] & ~wb_dat_i[ADCSQ_CTRL_EN])) begin
            state <= ST_IDLE;
          end else begin
            core_start_o <= 1'b1;
            state        <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (~core_en_o) begin
            state <= ST_IDLE;
          end else if (core_done_i) begin
            if (mult && core_chan_o != ADCSQ_LAST_CH) begin
              core_chan_o <= core_chan_o + 3'h1;
              state       <= ST_ISSUE;
            end else if (scan) begin
              core_chan_o <= first_ch;
              state       <= ST_ISSUE;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // done flag and converter request

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cd_flag <= ADCSQ_RST_BIT;
    end else if (pass_done) begin
      cd_flag <= 1'b1;
    end else if (acc_rd & hit_ctrl) begin
      cd_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_irq_o <= 1'b0;
    end else if (pass_done & irq_en) begin
      conv_irq_o <= 1'b1;
    end else if ((acc_rd & hit_ctrl) | ~irq_en) begin
      conv_irq_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data-available flags

  always_comb begin
    set_mask = '0;
    clr_mask = '0;
    if (store) begin
      set_mask[core_chan_o] = 1'b1;
    end
    if (acc_rd & hit_res) begin
      clr_mask[widx[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avail <= '0;
    end else begin
      // set on store, clear own bit on read
      avail <= (avail & ~clr_mask) | set_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // results and event interrupt

  // a word changes only when its channel converts again
  adcsq_result_mem #(
    .DEPTH (NUM_CH),
    .WIDTH (RES_W)
  ) u_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (store),
    .wr_addr_i (core_chan_o),
    .wr_data_i (core_data_i),
    .rd_addr_i (widx[2:0]),
    .rd_data_o (mem_rdata)
  );

  adcsq_evt_irq #(
    .N (ADCSQ_EVT_N)
  ) u_evt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .evt_i    ({overrun, store, pass_done}),
    .clr_wr_i (acc_wr & hit_clr & wb_sel_i[0]),
    .en_wr_i  (acc_wr & hit_en & wb_sel_i[0]),
    .wdata_i  (wb_dat_i[ADCSQ_EVT_N-1:0]),
    .status_o (evt_stat),
    .enable_o (evt_en),
    .irq_o    (irq_o)
  );

endmodule

/* verif/adcsq_core_model.sv */
// behavioural analog core: one done pulse per start pulse
`timescale 1ns/1ps
module adcsq_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       start_i,
  input  wire logic [2:0] chan_i,
  input  wire logic [6:0] tag_i,
  input  wire logic       slow_i,
  output logic            done_o,
  output logic      [9:0] data_o
);
  logic       busy;
  logic [2:0] cnt;
  // done pulse carries result
  // data flips outside the done cycle so a stale value never looks valid
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    cnt    <= cnt - 3'h1;
    if (rst_i || !en_i) begin
      busy   <= 1'b0;
      data_o <= 10'h155;
    end else if (start_i) begin
      busy <= 1'b1;
      cnt  <= slow_i ? 3'h5 : 3'h1;
    end else if (busy && cnt == 3'h1) begin
      busy   <= 1'b0;
      done_o <= 1'b1;
      data_o <= {chan_i, tag_i};
    end
  end
endmodule

/* verif/adcsq_assertions.sv */
// port-level checks of the converter sequencer
`timescale 1ns/1ps
module adcsq_checker
  import adcsq_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [2:0] bus_ctx_i,
  input wire logic       wb_ack_o,
  input wire logic       core_en_o,
  input wire logic       core_start_o,
  input wire logic       core_done_i,
  input wire logic       conv_irq_o,
  input wire logic [2:0] irq_ctx_o,
  input wire logic [2:0] irq_prio_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic ctrl_wr;
  assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADCSQ_OFF_CTRL;
  sequence s_ctrl_rd;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o && wb_adr_i == ADCSQ_OFF_CTRL;
  endsequence
  sequence s_ack_wait;
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_lat;
    $rose(wb_cyc_i && wb_stb_i) |-> s_ack_wait;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("bus answer timing wrong");
  property p_start_pulse;
    core_start_o |=> !core_start_o [*2];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_start_en;
    core_start_o |-> core_en_o;
  endproperty
  a_start_en: assert property (p_start_en) else $error("start while disabled");
  property p_irq_cause;
    $rose(conv_irq_o) |-> $past(core_done_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without done");
  // a done in the same window may set the request again
  property p_irq_ack;
    s_ctrl_rd ##0 (!core_done_i && !$past(core_done_i)) |=> !conv_irq_o;
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("request kept after read");
  property p_prio_src;
    $changed(irq_prio_o) |-> $past(ctrl_wr);
  endproperty
  a_prio_src: assert property (p_prio_src) else $error("priority moved alone");
  property p_ctx_src;
    $changed(irq_ctx_o) |-> $past(ctrl_wr && bus_ctx_i == ADCSQ_MASTER_CTX);
  endproperty
  a_ctx_src: assert property (p_ctx_src) else $error("context moved wrongly");
  property p_ctx_range;
    irq_ctx_o <= ADCSQ_CTX_MAX;
  endproperty
  a_ctx_range: assert property (p_ctx_range) else $error("reserved context held");
endmodule
bind adcsq_top adcsq_checker i_adcsq_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .bus_ctx_i(bus_ctx_i), .wb_ack_o(wb_ack_o),
  .core_en_o(core_en_o), .core_start_o(core_start_o), .core_done_i(core_done_i),
  .conv_irq_o(conv_irq_o), .irq_ctx_o(irq_ctx_o), .irq_prio_o(irq_prio_o)
);

/* verif/tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
  import adcsq_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0]  mask;
    logic [6:0]  tag;
  } adcsq_row_type;
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic [2:0]  ctx = 3'h0;
  logic [6:0]  tag = 7'h00;
  logic        slow = 1'b0;
  logic [31:0] q;
  logic [31:0] exp;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, core_en_o, core_start_o, core_done_i, conv_irq_o, irq_o;
  logic [2:0]  core_chan_o, irq_ctx_o, irq_prio_o;
  logic [9:0]  core_data_i;
  int          failures = 0;
  int          n_checks = 0;
  adcsq_row_type rows [5] = '{'{32'h80, 8'h01, 7'h11}, '{32'h8f, 8'h80, 7'h22},
    '{32'h83, 8'h08, 7'h33}, '{32'ha5, 8'hff, 7'h44}, '{32'ha8, 8'hff, 7'h55}};
  logic [7:0]  rst_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h40};

  adcsq_top i_adcsq_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .bus_ctx_i(ctx),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_en_o(core_en_o),
    .core_start_o(core_start_o), .core_chan_o(core_chan_o), .core_done_i(core_done_i),
    .core_data_i(core_data_i), .conv_irq_o(conv_irq_o), .irq_ctx_o(irq_ctx_o),
    .irq_prio_o(irq_prio_o), .irq_o(irq_o));
  adcsq_core_model i_adcsq_core_model (.clk_i(clk_i), .rst_i(rst_i), .en_i(core_en_o),
    .start_i(core_start_o), .chan_i(core_chan_o), .tag_i(tag), .slow_i(slow),
    .done_o(core_done_i), .data_o(core_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    r = wb_dat_o;
    req <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  // polls with a bounded count of reads
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    int n;
    n = 0;
    rd(a, r);
    while ((r & m) !== v && n < 300) begin
      rd(a, r);
      n++;
    end
    if (n >= 300) begin
      failures++;
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      tag <= rows[i].tag;
      wr(ADCSQ_OFF_CTRL, rows[i].ctrl);
      wr(ADCSQ_OFF_START, 32'h1);
      poll(ADCSQ_OFF_START, 32'h1, 32'h0);
      chk(32'(conv_irq_o), 32'(rows[i].ctrl[3]));
      rd(ADCSQ_OFF_CTRL, q);
      chk(32'(q[4]), 32'h1);
      chk(32'(conv_irq_o), 32'h0);
      exp = 32'(rows[i].mask);
      rd(ADCSQ_OFF_AVAIL, q);
      chk(q, exp);
      for (int c = 0; c < 8; c++) begin
        if (rows[i].mask[c]) begin
          rd(ADCSQ_OFF_RES_BASE + 8'(4 * c), q);
          chk(q, {22'h0, 3'(c), rows[i].tag});
          exp[c] = 1'b0;
          rd(ADCSQ_OFF_AVAIL, q);
          chk(q, exp);
        end
      end
      $display("test row %0d done", i);
    end
    slow <= 1'b1;
    tag  <= 7'h66;
    wr(ADCSQ_OFF_CTRL, 32'h83);
    wr(ADCSQ_OFF_START, 32'h1);
    wr(ADCSQ_OFF_START, 32'h0);
    rd(ADCSQ_OFF_START, q);
    chk(q, 32'h1);
    poll(ADCSQ_OFF_START, 32'h1, 32'h0);
    rd(8'h2c, q);
    chk(q, {22'h0, 3'h3, 7'h66});
    rd(8'h20, q);
    chk(q, {22'h0, 3'h0, 7'h55});
    slow <= 1'b0;
    $display("test start lock done");
    ctx <= 3'h1;
    wr(ADCSQ_OFF_CTRL, 32'h1f80);
    chk(32'(irq_prio_o), 32'h7);
    chk(32'(irq_ctx_o), 32'h0);
    ctx <= 3'h0;
    wr(ADCSQ_OFF_CTRL, 32'h1f80);
    chk(32'(irq_ctx_o), 32'h3);
    wr(ADCSQ_OFF_CTRL, 32'h2f80);
    chk(32'(irq_ctx_o), 32'h3);
    $display("test context done");
    tag <= 7'h0a;
    wr(ADCSQ_OFF_CTRL, 32'he0);
    wr(ADCSQ_OFF_START, 32'h1);
    poll(ADCSQ_OFF_AVAIL, 32'hff, 32'hff);
    tag <= 7'h0b;
    repeat (2) begin
      rd(8'h20, q);
      poll(ADCSQ_OFF_AVAIL, 32'h1, 32'h1);
    end
    rd(8'h24, q);
    chk(q, {22'h0, 3'h1, 7'h0b});
    rd(ADCSQ_OFF_START, q);
    chk(q, 32'h1);
    wr(ADCSQ_OFF_CTRL, 32'h60);
    chk(32'(core_en_o), 32'h0);
    poll(ADCSQ_OFF_START, 32'h1, 32'h0);
    $display("test scan done");
    tag <= 7'h0c;
    rd(8'h28, q);
    wr(ADCSQ_OFF_CTRL, 32'hc2);
    wr(ADCSQ_OFF_START, 32'h1);
    repeat (2) begin
      poll(ADCSQ_OFF_AVAIL, 32'h4, 32'h4);
      rd(8'h28, q);
    end
    chk(q, {22'h0, 3'h2, 7'h0c});
    rd(ADCSQ_OFF_START, q);
    chk(q, 32'h1);
    wr(ADCSQ_OFF_CTRL, 32'h82);
    poll(ADCSQ_OFF_START, 32'h1, 32'h0);
    $display("test single scan done");
    rd(ADCSQ_OFF_EVT_STAT, q);
    chk(q, 32'h7);
    wr(ADCSQ_OFF_EVT_EN, 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(ADCSQ_OFF_EVT_EN, 32'h0);
    chk(32'(irq_o), 32'h0);
    wr(ADCSQ_OFF_EVT_CLR, 32'h7);
    wr(ADCSQ_OFF_EVT_EN, 32'h7);
    rd(ADCSQ_OFF_EVT_STAT, q);
    chk(q, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("test events done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h40, 32'hffff_ffff);
    foreach (rst_adr[k]) begin
      rd(rst_adr[k], q);
      chk(q, ADCSQ_RST_W);
    end
    $display("test reset done");
    wrap_up();
  end
endmodule
